// file: hw/rsa_pkg.sv
// Purpose: Shared constants and carrier types of the raster scan address block.
// Assumes: 32-bit AHB-Lite register bus, one word per register.
// Notes:   Widths live here because the packed state structs need them.

package rsa_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [31:0] ADDR_BACKLIGHT_DUTY  = 32'h8003_0020;
    localparam logic [31:0] ADDR_VIDEO_ATTRIB    = 32'h8003_0024;
    localparam logic [31:0] ADDR_FRAME_START     = 32'h8003_0028;
    localparam logic [31:0] ADDR_SCAN_LINE_WORDS = 32'h8003_0034;
    localparam logic [31:0] ADDR_SCAN_STRIDE     = 32'h8003_0038;
    localparam logic [31:0] ADDR_CARRY_POINT     = 32'h8003_003C;
    localparam logic [31:0] ADDR_SPLIT_OFFSET    = 32'h8003_0230;
    localparam logic [31:0] ADDR_SCAN_STATUS     = 32'h8003_0240;

    // ************************************************************
    // Field widths and positions
    // ************************************************************
    localparam int ADDR_W   = 26;
    localparam int WORDS_W  = 12;
    localparam int STRIDE_W = 13;
    localparam int CARRY_W  = 11;
    localparam int SPLIT_W  = 16;
    localparam int ATTR_W   = 22;
    localparam int PERIOD_LO    = 0;
    localparam int THRESHOLD_LO = 8;
    localparam int FIELD8_W     = 8;
    localparam int ATTR_ENABLE  = 0;
    localparam int ATTR_PCLKOUT = 1;
    localparam int ATTR_SYNCOUT = 2;
    localparam int ATTR_DATAOUT = 3;
    localparam int ATTR_INTSTAT = 15;
    localparam int ATTR_BANK_LO = 20;
    localparam int STATUS_BUSY  = 31;
    localparam int STATUS_ODD   = 30;

    // ************************************************************
    // Reset values, bus codes and buffer depth
    // ************************************************************
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
    localparam logic        HRESP_OKAY   = 1'h0;
    localparam logic [3:0]  CS_ONE_HOT   = 4'h1;
    localparam int          BUF_DEPTH    = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SCAN_IDLE  = 2'h1,
        SCAN_FETCH = 2'h2
    } rsa_scan_t;

    // One fetched word request towards the frame buffer.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              lastWord;
    } rsa_fetch_t;

    typedef struct packed {
        logic [FIELD8_W-1:0] threshold;
        logic [FIELD8_W-1:0] period;
    } rsa_duty_t;

    // State of the top module, apart from its fetch buffer.
    typedef struct packed {
        rsa_duty_t           duty;
        logic [ATTR_W-1:0]   attr;
        logic [ADDR_W-1:0]   frameStart;
        logic [WORDS_W-1:0]  lineWords;
        logic [STRIDE_W-1:0] stride;
        logic [CARRY_W-1:0]  carryPoint;
        logic [SPLIT_W-1:0]  splitOffset;
        logic                wrPend;
        logic [31:0]         wrAddr;
        logic [31:0]         hrdata;
        logic                hreadyout;
        rsa_scan_t           scan;
        logic [ADDR_W-1:0]   curAddr;
        logic [ADDR_W-1:0]   lineBase;
        logic [WORDS_W-1:0]  wordsLeft;
        logic                oddLine;
        logic [FIELD8_W-1:0] dutyCount;
        logic                pwm;
        logic                carry;
        logic [CARRY_W-1:0]  prevH;
        logic [3:0]          chipSelN;
    } rsa_state_t;

endpackage

// file: hw/rsa_pair_buffer.sv
// Purpose: Small shift buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Head entry is a flip-flop, so the drain side sees registered outputs.

`timescale 1ns/1ns

module rsa_pair_buffer #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0]        vld;
    } rsa_buf_state_t;

    rsa_buf_state_t s_reg;
    rsa_buf_state_t s_next;
    logic           placed;

    // Pop shifts every entry down one place, then a push fills the lowest free slot.
    always_comb begin
        s_next = s_reg;
        placed = 1'b0;
        if (s_reg.vld[0] && outReady) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_next.mem[i] = s_reg.mem[i + 1];
                s_next.vld[i] = s_reg.vld[i + 1];
            end
            s_next.vld[DEPTH-1] = 1'b0;
        end
        if (inValid && !s_reg.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!s_next.vld[i] && !placed) begin
                    s_next.mem[i] = inData;
                    s_next.vld[i] = 1'b1;
                    placed        = 1'b1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Ready only looks at the stored fill, never at the drain side, to keep paths short.
    assign inReady  = !s_reg.vld[DEPTH-1];
    assign outValid = s_reg.vld[0];
    assign outData  = s_reg.mem[0];

endmodule

// file: hw/rsa_scan_engine.sv
// Purpose: Frame buffer scan address generator, line carry and backlight duty waveform.
// Assumes: Timing generator on sys_clk supplies the horizontal down count and line/frame
//          pulses; registers are reached over AHB-Lite with zero wait states.
// Notes:   Contract
// Contract
// R1: Fetch each line as programmed word count.
// R2: Leftover pixels pass, flushed during blanking.
// R3: Add stride after each line's words.
// R4: Carry at programmed horizontal count value.
// R5: Nonzero split offset added every second line.
// R6: Duty counter counts lines down from period.
// R7: Counter at or above threshold drives low.
// R8: Counter below threshold drives output high.
// R9: Backlight output low after reset.
// R10: Bank field picks one of four selects.
// R11: Attribute bit layout, enable at bit zero.
// R12: Bank values map to selects zero to three.
// R13: Frame start is top-left word address.
// R14: Enable bit stops or runs scanning.
// R15: Reload address from frame start each frame.

`timescale 1ns/1ns

module rsa_scan_engine
    import rsa_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic [31:0]                       hrdata,
    output logic                              hresp,
    input  wire logic [rsa_pkg::CARRY_W-1:0]  hCount,
    input  wire logic                         lineStart,
    input  wire logic                         frameStart,
    output logic                              fetchValid,
    input  wire logic                         fetchReady,
    output rsa_pkg::rsa_fetch_t               fetchWord,
    output logic [3:0]                        sdramChipSelN,
    output logic                              backlightPwmOut,
    output logic                              verticalCarry,
    output logic                              videoEnable,
    output logic                              pixelClockOutEnable,
    output logic                              syncOutEnable,
    output logic                              pixelDataOutEnable
);

    import rsa_pkg::*;

    // ************************************************************
    // State and buffer wiring
    // ************************************************************
    rsa_state_t s_reg;
    rsa_state_t s_next;
    rsa_fetch_t pushWord;
    logic       pushValid;
    logic       pushReady;
    logic       addrPhase;

    // Read multiplexer; it is fed the next state so a write in its data phase
    // is seen by a read whose address phase falls in the same cycle.
    function automatic logic [31:0] readValue(input rsa_state_t r, input logic [31:0] a);
        logic [31:0] v;
        v = RESET_WORD;
        case (a)
            ADDR_BACKLIGHT_DUTY:  v = {16'h0000, r.duty};
            ADDR_VIDEO_ATTRIB:    v = {{(32 - ATTR_W){1'b0}}, r.attr};
            ADDR_FRAME_START:     v = {{(32 - ADDR_W){1'b0}}, r.frameStart};
            ADDR_SCAN_LINE_WORDS: v = {{(32 - WORDS_W){1'b0}}, r.lineWords};
            ADDR_SCAN_STRIDE:     v = {{(32 - STRIDE_W){1'b0}}, r.stride};
            ADDR_CARRY_POINT:     v = {{(32 - CARRY_W){1'b0}}, r.carryPoint};
            ADDR_SPLIT_OFFSET:    v = {{(32 - SPLIT_W){1'b0}}, r.splitOffset};
            ADDR_SCAN_STATUS: begin
                v = {{(32 - ADDR_W){1'b0}}, r.lineBase};
                v[STATUS_BUSY] = (r.scan == SCAN_FETCH);
                v[STATUS_ODD]  = r.oddLine;
            end
            default:              v = RESET_WORD;
        endcase
        return v;
    endfunction

    assign addrPhase = hsel && (htrans == HTRANS_NSEQ) && hready;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // One combinational pass over bus, scan, carry and duty state.
    always_comb begin
        s_next    = s_reg;
        pushValid = 1'b0;
        pushWord  = '0;

        // Bus data phase: commit the write captured in the previous address phase.
        if (s_reg.wrPend) begin
            case (s_reg.wrAddr)
                ADDR_BACKLIGHT_DUTY: begin
                    s_next.duty.threshold = hwdata[THRESHOLD_LO +: FIELD8_W];
                    s_next.duty.period    = hwdata[PERIOD_LO +: FIELD8_W];
                end
                ADDR_VIDEO_ATTRIB:    s_next.attr        = hwdata[ATTR_W-1:0]; // see R11
                ADDR_FRAME_START:     s_next.frameStart  = hwdata[ADDR_W-1:0];
                ADDR_SCAN_LINE_WORDS: s_next.lineWords   = hwdata[WORDS_W-1:0];
                ADDR_SCAN_STRIDE:     s_next.stride      = hwdata[STRIDE_W-1:0];
                ADDR_CARRY_POINT:     s_next.carryPoint  = hwdata[CARRY_W-1:0];
                ADDR_SPLIT_OFFSET:    s_next.splitOffset = hwdata[SPLIT_W-1:0];
                default:              s_next.wrPend      = 1'b0;
            endcase
        end

        // Bus address phase: only whole-word writes are kept, reads answer next cycle.
        s_next.wrPend    = 1'b0;
        s_next.hreadyout = 1'b1;
        if (addrPhase) begin
            s_next.wrPend = hwrite && (hsize == HSIZE_WORD);
            s_next.wrAddr = haddr;
            if (!hwrite) begin
                s_next.hrdata = readValue(s_next, haddr);
            end
        end

        // Scan address sequencer, held idle while the enable bit is clear.
        case (s_reg.scan)
            SCAN_IDLE: begin
                if (s_reg.attr[ATTR_ENABLE] && lineStart && (s_reg.lineWords != '0)) begin
                    s_next.curAddr   = s_reg.lineBase;
                    s_next.wordsLeft = s_reg.lineWords; // see R1
                    s_next.scan      = SCAN_FETCH;
                end
            end
            SCAN_FETCH: begin
                pushValid         = 1'b1;
                pushWord.addr     = s_reg.curAddr;
                // The last word goes out whole; its spare pixels drain in blanking.
                pushWord.lastWord = (s_reg.wordsLeft == WORDS_W'(1)); // see R2
                if (pushReady) begin
                    s_next.curAddr   = s_reg.curAddr + ADDR_W'(1);
                    s_next.wordsLeft = s_reg.wordsLeft - WORDS_W'(1); // see R1
                    if (s_reg.wordsLeft == WORDS_W'(1)) begin
                        s_next.scan     = SCAN_IDLE;
                        s_next.oddLine  = !s_reg.oddLine;
                        // Next line starts past this line's words plus the stride.
                        s_next.lineBase = s_reg.curAddr + ADDR_W'(1)
                                        + ADDR_W'(s_reg.stride); // see R3
                        // Every second line also jumps by the split offset when set.
                        if (s_reg.oddLine && (s_reg.splitOffset != '0)) begin
                            s_next.lineBase = s_reg.curAddr + ADDR_W'(1)
                                            + ADDR_W'(s_reg.stride)
                                            + ADDR_W'(s_reg.splitOffset); // see R5
                        end
                    end
                end
            end
            default: begin
                s_next.scan = SCAN_IDLE;
            end
        endcase

        // Disabling the sequencer drops any line in progress at once.
        if (!s_reg.attr[ATTR_ENABLE]) begin
            s_next.scan = SCAN_IDLE; // see R14
        end

        // A frame start wins over everything: restart from the top-left word.
        if (frameStart) begin
            s_next.lineBase = s_reg.frameStart; // see R13, R15
            s_next.oddLine  = 1'b0;
            s_next.scan     = SCAN_IDLE;
        end

        // Carry to the vertical counter once per pass of the horizontal count.
        s_next.prevH = hCount;
        s_next.carry = (hCount == s_reg.carryPoint) && (s_reg.prevH != hCount); // see R4

        // Duty counter steps once per line and reloads at the line start that finds it at zero.
        if (lineStart) begin
            if (s_reg.dutyCount == '0) begin
                s_next.dutyCount = s_reg.duty.period; // see R6
            end else begin
                s_next.dutyCount = s_reg.dutyCount - FIELD8_W'(1); // see R6
            end
        end
        // Output is high only while the count sits below the threshold.
        if (s_reg.dutyCount >= s_reg.duty.threshold) begin
            s_next.pwm = 1'b0; // see R7
        end else begin
            s_next.pwm = 1'b1; // see R8
        end

        // Active-low chip select picked by the two bank bits.
        s_next.chipSelN = ~(CS_ONE_HOT << s_reg.attr[ATTR_BANK_LO +: 2]); // see R10, R12
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Reset clears every register except scan, hreadyout and chipSelN, which leaves the backlight dark.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg           <= '0;
            s_reg.scan      <= SCAN_IDLE;
            s_reg.hreadyout <= 1'b1;
            s_reg.chipSelN  <= ~CS_ONE_HOT;
            s_reg.pwm       <= 1'b0; // see R9
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Fetch buffer
    // ************************************************************
    // Two entries let the memory side stall for a cycle without dropping a word;
    // a longer stall holds the sequencer through pushReady.
    rsa_pair_buffer #(
        .W     ($bits(rsa_fetch_t)),
        .DEPTH (BUF_DEPTH)
    ) u_fetch_buffer (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (fetchValid),
        .outReady (fetchReady),
        .outData  (fetchWord)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output below except hresp is a register field; the response is always OKAY.
    assign hreadyout           = s_reg.hreadyout;
    assign hrdata              = s_reg.hrdata;
    assign hresp               = HRESP_OKAY;
    assign sdramChipSelN       = s_reg.chipSelN;
    assign backlightPwmOut     = s_reg.pwm;
    assign verticalCarry       = s_reg.carry;
    assign videoEnable         = s_reg.attr[ATTR_ENABLE];  // see R11, R14
    assign pixelClockOutEnable = s_reg.attr[ATTR_PCLKOUT]; // see R11
    assign syncOutEnable       = s_reg.attr[ATTR_SYNCOUT]; // see R11
    assign pixelDataOutEnable  = s_reg.attr[ATTR_DATAOUT]; // see R11

endmodule

// file: tb/rsa_scan_engine_chk.sv
// Purpose: Port-level checks of the raster scan address block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Register contents are judged by the bench, not here.

`timescale 1ns/1ns

module rsa_scan_chk (
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    input wire logic [rsa_pkg::CARRY_W-1:0] hCount,
    input wire logic                        frameStart,
    input wire logic                        fetchValid,
    input wire logic                        fetchReady,
    input wire rsa_pkg::rsa_fetch_t         fetchWord,
    input wire logic [3:0]                  sdramChipSelN,
    input wire logic                        backlightPwmOut,
    input wire logic                        verticalCarry,
    input wire logic                        videoEnable
);
    import rsa_pkg::*;

    logic              inLine_reg;
    logic [ADDR_W-1:0] prevAddr_reg;
    logic              taken;

    // ************************************************************
    // Helper state and properties
    // ************************************************************
    assign taken = fetchValid && fetchReady;

    // Track the last taken word; an abort forgets it.
    always_ff @(posedge sys_clk) begin
        if (!resetn || !videoEnable || frameStart) begin
            inLine_reg <= 1'b0;
        end else if (taken) begin
            inLine_reg <= !fetchWord.lastWord;
        end
        if (taken) begin
            prevAddr_reg <= fetchWord.addr;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_takenMid;
        taken && inLine_reg;
    endsequence
    sequence s_offQuiet;
        (!videoEnable)[*3] ##0 !fetchValid;
    endsequence

    property p_darkAfterReset;
        $rose(resetn) |-> !backlightPwmOut;
    endproperty
    property p_bankAfterReset;
        $rose(resetn) |-> sdramChipSelN == 4'hE;
    endproperty
    property p_oneBank;
        $onehot(~sdramChipSelN);
    endproperty
    property p_carryCause;
        verticalCarry |-> $past(hCount) != $past(hCount, 2);
    endproperty
    property p_carryPulse;
        verticalCarry |=> !verticalCarry;
    endproperty
    property p_holdWord;
        fetchValid && !fetchReady && videoEnable && !frameStart
            |=> fetchValid && $stable(fetchWord);
    endproperty
    property p_lineStep;
        s_takenMid |-> fetchWord.addr == ADDR_W'(prevAddr_reg + 26'h1);
    endproperty
    property p_idleWhenOff;
        s_offQuiet |=> !fetchValid;
    endproperty

    a_darkAfterReset: assert property (p_darkAfterReset) else $error("light after reset");
    a_bankAfterReset: assert property (p_bankAfterReset) else $error("bad reset bank");
    a_oneBank: assert property (p_oneBank) else $error("select not one-hot");
    a_carryCause: assert property (p_carryCause) else $error("carry without count");
    a_carryPulse: assert property (p_carryPulse) else $error("carry too long");
    a_holdWord: assert property (p_holdWord) else $error("word dropped");
    a_lineStep: assert property (p_lineStep) else $error("word skipped");
    a_idleWhenOff: assert property (p_idleWhenOff) else $error("fetch while off");
endmodule

bind rsa_scan_engine rsa_scan_chk u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .hCount(hCount), .frameStart(frameStart),
    .fetchValid(fetchValid), .fetchReady(fetchReady), .fetchWord(fetchWord),
    .sdramChipSelN(sdramChipSelN), .backlightPwmOut(backlightPwmOut),
    .verticalCarry(verticalCarry), .videoEnable(videoEnable)
);

// file: tb/rsa_frame_sink.sv
// Purpose: Frame buffer side that drains the fetch stream and logs each word.
// Assumes: Same clock as the block.
// Notes:   Slow mode stalls two cycles of three to fill the buffer.

`timescale 1ns/1ns

module rsa_frame_sink (
    input wire logic                sys_clk,
    input wire logic                resetn,
    input wire logic                slow,
    input wire logic                fetchValid,
    output logic                    fetchReady,
    input wire rsa_pkg::rsa_fetch_t fetchWord
);
    import rsa_pkg::*;

    rsa_fetch_t got [64];
    int         nGot;
    logic [1:0] phase;

    // Log a word at each edge with valid and ready high.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            nGot <= 0;
            phase <= 2'h0;
            fetchReady <= 1'b0;
        end else begin
            if (fetchValid && fetchReady) begin
                got[nGot[5:0]] <= fetchWord;
                nGot <= nGot + 1;
            end
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            fetchReady <= !slow || phase == 2'h1;
        end
    end
endmodule

// file: tb/raster_scan_address_and_backlight_bench.sv
// Purpose: Self-checking bench of the raster scan address block.
// Assumes: 32-cycle lines from a stand-in timing generator.
// Notes:   Counts span whole waveform periods.

`timescale 1ns/1ns

module raster_scan_address_and_backlight_bench;
    import rsa_pkg::*;

    typedef struct {logic [31:0] addr, data, exp; int kind;} rsa_row_t;
    logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, lineStart = 0, frameStart = 0;
    logic slow = 0, hready, hreadyout, hresp, fetchValid, fetchReady, verticalCarry;
    logic backlightPwmOut, videoEnable, pixelClockOutEnable, syncOutEnable, pixelDataOutEnable;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [3:0] sdramChipSelN;
    logic [CARRY_W-1:0] hCount = 0;
    rsa_fetch_t fetchWord;
    int errors = 0, n_tests = 0, cnt;
    rsa_row_t rows[11] = '{'{ADDR_BACKLIGHT_DUTY, '1, 32'h0000_FFFF, 0},
        '{ADDR_VIDEO_ATTRIB, '1, 32'h003F_FFFF, 0}, '{ADDR_FRAME_START, '1, 32'h03FF_FFFF, 0},
        '{ADDR_SCAN_LINE_WORDS, '1, 32'hFFF, 0}, '{ADDR_SCAN_STRIDE, '1, 32'h1FFF, 0},
        '{ADDR_CARRY_POINT, '1, 32'h7FF, 0}, '{ADDR_SPLIT_OFFSET, '1, 32'hFFFF, 0},
        '{32'h8003_0100, '1, 32'h0, 0}, '{ADDR_CARRY_POINT, 32'hA, 32'h8, 1},
        '{ADDR_CARRY_POINT, 32'h0, 32'h8, 1}, '{ADDR_CARRY_POINT, 32'h20, 32'h0, 1}};
    logic [31:0] duty[3] = '{32'h0203, 32'h0003, 32'h0403};
    int dutyExp[3] = '{128, 0, 256};

    assign hready = hreadyout;
    always #2 sys_clk = ~sys_clk;

    // Stand-in timing generator: count down 31..0, line pulse on wrap.
    always @(posedge sys_clk) begin
        hCount <= (hCount == 11'h000) ? 11'h01F : hCount - 11'h001;
        lineStart <= (hCount == 11'h001);
    end

    rsa_scan_engine dut (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .hCount, .lineStart, .frameStart, .fetchValid,
        .fetchReady, .fetchWord, .sdramChipSelN, .backlightPwmOut, .verticalCarry,
        .videoEnable, .pixelClockOutEnable, .syncOutEnable, .pixelDataOutEnable);
    rsa_frame_sink sink (.sys_clk, .resetn, .slow, .fetchValid, .fetchReady, .fetchWord);

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single transfer; each phase ends at a rising edge that sees hready high.
    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [31:0] a, exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    // Counts cycles with the carry (sel 0) or the backlight (sel 1) high.
    task automatic tally(input int sel, input int span);
        repeat (64) @(posedge sys_clk);
        cnt = 0;
        repeat (span) begin
            @(negedge sys_clk);
            cnt += (sel == 0) ? int'(verticalCarry === 1'b1) : int'(backlightPwmOut === 1'b1);
        end
        @(posedge sys_clk);
    endtask

    // Scans one frame of four 3-word lines, base 0x100, stride 5.
    task automatic frame(input logic [15:0] split, input logic s);
        int n0;
        logic [25:0] base;
        rsa_fetch_t w;
        wr(ADDR_SPLIT_OFFSET, {16'h0, split});
        slow <= s;
        while (fetchValid) @(posedge sys_clk);
        frameStart <= 1'b1;
        @(posedge sys_clk);
        frameStart <= 1'b0;
        n0 = sink.nGot;
        base = 26'h100;
        wr(ADDR_VIDEO_ATTRIB, 32'h1);
        while (sink.nGot < n0 + 12) @(posedge sys_clk);
        wr(ADDR_VIDEO_ATTRIB, 32'h0);
        for (int k = 0; k < 12; k++) begin
            w = sink.got[(n0 + k) % 64];
            check({w.addr, w.lastWord}, {26'(base + k % 3), 1'(k % 3 == 2)});
            if (k % 3 == 2) begin
                base = 26'(base + 26'h8 + (((k / 3) % 2 == 1) ? split : 16'h0));
            end
        end
    endtask

    task automatic test_done;
        $display("Checks: %0d, mismatches: %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        check(backlightPwmOut, 1'b0);
        check(sdramChipSelN, 4'hE);
        @(posedge sys_clk);
        foreach (rows[i]) begin
            if (rows[i].kind == 0) rdc(rows[i].addr, RESET_WORD);
            wr(rows[i].addr, rows[i].data);
            if (rows[i].kind == 0) begin
                rdc(rows[i].addr, rows[i].exp);
                wr(rows[i].addr, 32'h0);
            end else begin
                tally(0, 256);
                check(cnt, rows[i].exp);
            end
        end
        foreach (duty[i]) begin
            wr(ADDR_BACKLIGHT_DUTY, duty[i]);
            tally(1, 256);
            check(cnt, dutyExp[i]);
        end
        wr(ADDR_FRAME_START, 32'h100);
        wr(ADDR_SCAN_LINE_WORDS, 32'h3);
        wr(ADDR_SCAN_STRIDE, 32'h5);
        frame(16'h0040, 1'b1);
        frame(16'h0000, 1'b0);
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_VIDEO_ATTRIB, (32'(b) << ATTR_BANK_LO) | (32'h1 << b));
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            check(sdramChipSelN, 4'(~(4'h1 << b)));
            check({pixelDataOutEnable, syncOutEnable, pixelClockOutEnable, videoEnable},
                  4'(4'h1 << b));
            @(posedge sys_clk);
        end
        check(hresp, HRESP_OKAY);
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        check({backlightPwmOut, fetchValid, sdramChipSelN}, 6'h0E);
        @(posedge sys_clk);
        rdc(ADDR_BACKLIGHT_DUTY, RESET_WORD);
        test_done;
    end

    // Ends a hang; a clean run takes about a tenth of this.
    initial begin
        #100000;
        errors++;
        test_done;
    end
endmodule
